/* hdl/bcr_pkg.sv */
// Purpose: shared constants and types for the buck configuration register bank
// Assumes: single 250 MHz clock domain
// Notes: addresses are the I2C register pointer values
package bcr_pkg;

    localparam int NUM_BUCK = 4;
    localparam int OTP_PER_BUCK = 3;
    localparam int NUM_SEQ = 3;

    // i2c target and register pointers
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h3C;
    localparam logic [7:0] BUCK0_SLEW_AND_POWER_MODE_ADDR = 8'h1D;
    localparam logic [7:0] BUCK1_SLEW_AND_POWER_MODE_ADDR = 8'h1E;
    localparam logic [7:0] BUCK2_SLEW_AND_POWER_MODE_ADDR = 8'h1F;
    localparam logic [7:0] BUCK3_SLEW_AND_POWER_MODE_ADDR = 8'h20;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // field positions of buck_config_one
    localparam int RAMP_MSB = 7;
    localparam int RAMP_LSB = 6;
    localparam int MODE_MSB = 5;
    localparam int MODE_LSB = 4;
    localparam int OTP_HI_BIT = 5;
    localparam int OTP_MID_BIT = 4;
    localparam int OTP_LO_BIT = 1;

    // reset pattern 01xx_00x0, x filled from otp
    localparam logic [7:0] CFG_RESET_VALUE = 8'h40;

    // sequencer source and power mode codes
    localparam logic [1:0] SEQ_SRC_SOFTWARE = 2'h3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_GROUP_LP = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;

    // ramp rates in units of 10 uV/us: 13.75, 27.50, 55.00, 100 mV/us
    localparam int RAMP_W = 14;
    localparam logic [RAMP_W-1:0] RAMP_RATE_CODE0 = 14'h055F;
    localparam logic [RAMP_W-1:0] RAMP_RATE_CODE1 = 14'h0ABE;
    localparam logic [RAMP_W-1:0] RAMP_RATE_CODE2 = 14'h157C;
    localparam logic [RAMP_W-1:0] RAMP_RATE_CODE3 = 14'h2710;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        I2C_IDLE  = 3'b000,
        I2C_ADDR  = 3'b001,
        I2C_REG   = 3'b010,
        I2C_WDATA = 3'b011,
        I2C_ACK   = 3'b100,
        I2C_RDATA = 3'b101,
        I2C_MACK  = 3'b110
    } bcr_i2c_state_t;

endpackage : bcr_pkg

/* hdl/bcr_i2c_target.sv */
// Purpose: i2c target front end, register pointer with auto increment
// Assumes: scl and sda inputs synchronous to clk
// Notes: every matching byte is acknowledged, mapping is decided upstream
`timescale 1ns/1ps
`default_nettype none
module bcr_i2c_target
    import bcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);

    typedef struct packed {
        bcr_i2c_state_t st;
        bcr_i2c_state_t nxt;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic drv;
        logic scl;
        logic sda;
        logic wr;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } bcr_i2c_regs_t;

    bcr_i2c_regs_t state_q;
    bcr_i2c_regs_t state_d;
    logic rise;
    logic fall;
    logic start_cond;
    logic stop_cond;

    assign rise = scl & ~state_q.scl;
    assign fall = ~scl & state_q.scl;
    assign start_cond = scl & state_q.scl & state_q.sda & ~sda_i;
    assign stop_cond = scl & state_q.scl & ~state_q.sda & sda_i;

    always_comb begin
        state_d = state_q;
        state_d.wr = 1'b0;
        state_d.scl = scl;
        state_d.sda = sda_i;
        case (state_q.st)
            I2C_ADDR, I2C_REG, I2C_WDATA: begin
                if (rise && state_q.bitc != BITS_PER_BYTE) begin
                    state_d.sh = {state_q.sh[6:0], sda_i};
                    state_d.bitc = state_q.bitc + 4'h1;
                end
                if (fall && state_q.bitc == BITS_PER_BYTE) begin
                    state_d.bitc = 4'h0;
                    state_d.st = I2C_ACK;
                    state_d.drv = 1'b1;
                    if (state_q.st == I2C_ADDR) begin
                        state_d.nxt = state_q.sh[0] ? I2C_RDATA : I2C_REG;
                        if (state_q.sh[7:1] != I2C_TARGET_ADDR) begin
                            state_d.st = I2C_IDLE;
                            state_d.drv = 1'b0;
                        end
                    end else if (state_q.st == I2C_REG) begin
                        state_d.ptr = state_q.sh;
                        state_d.nxt = I2C_WDATA;
                    end else begin
                        state_d.wr = 1'b1;
                        state_d.wr_addr = state_q.ptr;
                        state_d.wr_data = state_q.sh;
                        state_d.ptr = state_q.ptr + 8'h01;
                        state_d.nxt = I2C_WDATA;
                    end
                end
            end
            I2C_ACK: begin
                if (fall) begin
                    state_d.drv = 1'b0;
                    state_d.st = state_q.nxt;
                    if (state_q.nxt == I2C_RDATA) begin
                        state_d.sh = rd_data;
                        state_d.ptr = state_q.ptr + 8'h01;
                        state_d.drv = ~rd_data[7];
                    end
                end
            end
            I2C_RDATA: begin
                if (fall) begin
                    if (state_q.bitc == BITS_PER_BYTE - 4'h1) begin
                        state_d.drv = 1'b0;
                        state_d.bitc = 4'h0;
                        state_d.st = I2C_MACK;
                    end else begin
                        state_d.sh = {state_q.sh[6:0], 1'b0};
                        state_d.drv = ~state_q.sh[6];
                        state_d.bitc = state_q.bitc + 4'h1;
                    end
                end
            end
            I2C_MACK: begin
                // master nack ends the read burst
                if (rise) begin
                    state_d.st = sda_i ? I2C_IDLE : I2C_ACK;
                    state_d.nxt = I2C_RDATA;
                end
            end
            default: begin
                state_d.st = state_q.st;
            end
        endcase
        if (start_cond) begin
            state_d.st = I2C_ADDR;
            state_d.bitc = 4'h0;
            state_d.drv = 1'b0;
        end else if (stop_cond) begin
            state_d.st = I2C_IDLE;
            state_d.drv = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{st: I2C_IDLE, nxt: I2C_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = ~state_q.drv;
    assign rd_addr = state_q.ptr;
    assign wr_stb = state_q.wr;
    assign wr_addr = state_q.wr_addr;
    assign wr_data = state_q.wr_data;

endmodule : bcr_i2c_target
`default_nettype wire

/* hdl/bcr_config_top.sv */
// Purpose: four buck configuration registers and their power mode decoders
// Assumes: RESETN and SHUTDOWN both act as global shutdown; pins synchronous to CLK
// Notes: otp bits are loaded on the first edge after reset release or with SHUTDOWN
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Global shutdown restores each register to 01xx_00x0 with bits 5, 4 and 1 from otp.
// - Bits 7:6 pick the ramp rate: 13.75, 27.50, 55.00 or 100 mV/us.
// - Bits 5:4 are the power mode, decoded by whether the sequencer source is 0b11 or a sequencer.
// - Software control, mode 00: buck off unless the enable pin overrides buck zero.
// - Software control, mode 01: normal mode when global low power is low, low power when high.
// - Software control, mode 10: always low-power mode.
// - Software control, mode 11: always normal mode.
// - Sequencer control, mode 00: off while the sequencer is inactive, normal while active.
// - Sequencer control, mode 01: off while inactive, otherwise follows global low power.
// - Sequencer control, mode 10: off while inactive, low power while active.
// - Sequencer control, mode 11 acts as mode 00.
// - For buck zero a high second enable pin turns the buck on whatever the mode.
module bcr_config_top
    import bcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SHUTDOWN,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic [bcr_pkg::NUM_BUCK*bcr_pkg::OTP_PER_BUCK-1:0] OTP_BITS,
    input wire logic [2*bcr_pkg::NUM_BUCK-1:0] SEQ_SRC,
    input wire logic [bcr_pkg::NUM_SEQ-1:0] SEQ_ACTIVE,
    input wire logic GLOBAL_LOW_POWER,
    input wire logic SECOND_ENABLE_PIN,
    output logic [bcr_pkg::NUM_BUCK-1:0] BUCK_EN,
    output logic [bcr_pkg::NUM_BUCK-1:0] BUCK_LP,
    output logic [2*bcr_pkg::NUM_BUCK-1:0] BUCK_RAMP_SEL,
    output logic [bcr_pkg::NUM_BUCK*bcr_pkg::RAMP_W-1:0] BUCK_RAMP_RATE
);
    import bcr_pkg::*;

    typedef struct packed {
        logic [NUM_BUCK-1:0][7:0] cfg;
        logic otp_done;
        logic [NUM_BUCK-1:0] en;
        logic [NUM_BUCK-1:0] lp;
        logic [NUM_BUCK-1:0][RAMP_W-1:0] ramp;
    } bcr_bank_t;

    bcr_bank_t state_q;
    bcr_bank_t state_d;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic load_otp;

    // register pointer to bank index, bit 2 flags a hit
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            BUCK0_SLEW_AND_POWER_MODE_ADDR: reg_index = 3'h4;
            BUCK1_SLEW_AND_POWER_MODE_ADDR: reg_index = 3'h5;
            BUCK2_SLEW_AND_POWER_MODE_ADDR: reg_index = 3'h6;
            BUCK3_SLEW_AND_POWER_MODE_ADDR: reg_index = 3'h7;
            default: reg_index = 3'h0;
        endcase
    endfunction : reg_index

    function automatic logic [RAMP_W-1:0] ramp_rate(input logic [1:0] code);
        case (code)
            2'h0: ramp_rate = RAMP_RATE_CODE0;
            2'h1: ramp_rate = RAMP_RATE_CODE1;
            2'h2: ramp_rate = RAMP_RATE_CODE2;
            default: ramp_rate = RAMP_RATE_CODE3;
        endcase
    endfunction : ramp_rate

    // returns {enable, low_power}
    function automatic logic [1:0] power_decode(
        input logic [1:0] src,
        input logic [1:0] mode,
        input logic [NUM_SEQ-1:0] act,
        input logic glp,
        input logic pin
    );
        logic en;
        logic lp;
        en = 1'b0;
        lp = 1'b0;
        if (src == SEQ_SRC_SOFTWARE) begin
            case (mode)
                MODE_OFF: en = 1'b0;
                MODE_GROUP_LP: begin
                    en = 1'b1;
                    lp = glp;
                end
                MODE_LOW_POWER: begin
                    en = 1'b1;
                    lp = 1'b1;
                end
                default: en = 1'b1;
            endcase
        end else if (act[src]) begin
            case (mode)
                MODE_GROUP_LP: begin
                    en = 1'b1;
                    lp = glp;
                end
                MODE_LOW_POWER: begin
                    en = 1'b1;
                    lp = 1'b1;
                end
                default: en = 1'b1;
            endcase
        end
        if (pin && !en) begin
            en = 1'b1;
            lp = 1'b0;
        end
        power_decode = {en, lp};
    endfunction : power_decode

    bcr_i2c_target u_i2c (
        .clk(CLK),
        .rst_n(RESETN),
        .scl(SCL),
        .sda_i(SDA_I),
        .sda_o(SDA_O),
        .sda_oe_n(SDA_OE_N),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    assign load_otp = !state_q.otp_done || SHUTDOWN;

    always_comb begin
        logic [2:0] rd_idx;
        rd_idx = reg_index(rd_addr);
        rd_data = rd_idx[2] ? state_q.cfg[rd_idx[1:0]] : UNMAPPED_READ_VALUE;
    end

    always_comb begin
        logic [2:0] wr_idx;
        logic [1:0] dec;
        wr_idx = reg_index(wr_addr);
        dec = 2'h0;
        state_d = state_q;
        if (load_otp) begin
            state_d.otp_done = 1'b1;
            for (int i = 0; i < NUM_BUCK; i++) begin
                state_d.cfg[i] = CFG_RESET_VALUE;
                state_d.cfg[i][OTP_HI_BIT] = OTP_BITS[OTP_PER_BUCK*i+2];
                state_d.cfg[i][OTP_MID_BIT] = OTP_BITS[OTP_PER_BUCK*i+1];
                state_d.cfg[i][OTP_LO_BIT] = OTP_BITS[OTP_PER_BUCK*i];
            end
        end else if (wr_stb && wr_idx[2]) begin
            state_d.cfg[wr_idx[1:0]] = wr_data;
        end
        for (int i = 0; i < NUM_BUCK; i++) begin
            dec = power_decode(SEQ_SRC[2*i+:2], state_q.cfg[i][MODE_MSB:MODE_LSB], SEQ_ACTIVE,
                               GLOBAL_LOW_POWER, (i == 0) && SECOND_ENABLE_PIN);
            state_d.en[i] = dec[1];
            state_d.lp[i] = dec[0];
            state_d.ramp[i] = ramp_rate(state_q.cfg[i][RAMP_MSB:RAMP_LSB]);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= '{cfg: {NUM_BUCK{CFG_RESET_VALUE}}, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BUCK; g++) begin : g_out
            assign BUCK_RAMP_SEL[2*g+:2] = state_q.cfg[g][RAMP_MSB:RAMP_LSB];
            assign BUCK_RAMP_RATE[RAMP_W*g+:RAMP_W] = state_q.ramp[g];
        end
    endgenerate

    assign BUCK_EN = state_q.en;
    assign BUCK_LP = state_q.lp;

    // checking helpers for buck one
    logic [1:0] src1;
    logic [1:0] mode1;
    logic seq_act1;
    assign src1 = SEQ_SRC[3:2];
    assign mode1 = state_q.cfg[1][MODE_MSB:MODE_LSB];
    assign seq_act1 = (src1 == SEQ_SRC_SOFTWARE) ? 1'b0 : SEQ_ACTIVE[src1];

    default clocking cb @(posedge CLK);
    endclocking
    // release edge still decodes reset values, so skip until otp is in
    default disable iff (!RESETN || !state_q.otp_done);

    a_reg_write_map: assert property (
        (wr_stb && wr_addr == BUCK1_SLEW_AND_POWER_MODE_ADDR && !load_otp)
        |=> (state_q.cfg[1] == $past(wr_data))
    ) else $error("write to buck one register not stored");

    a_unmapped_ignored: assert property (
        (wr_stb && !load_otp
         && (wr_addr < BUCK0_SLEW_AND_POWER_MODE_ADDR || wr_addr > BUCK3_SLEW_AND_POWER_MODE_ADDR))
        |=> $stable(state_q.cfg)
    ) else $error("unmapped write changed a register");

    a_shutdown_pattern: assert property (
        SHUTDOWN
        |=> (state_q.cfg[2][7:6] == 2'h1 && state_q.cfg[2][3:2] == 2'h0
             && state_q.cfg[2][5] == $past(OTP_BITS[8]) && state_q.cfg[2][1] == $past(OTP_BITS[6]))
    ) else $error("shutdown pattern wrong");

    a_ramp_fastest: assert property (
        (wr_stb && wr_addr == BUCK0_SLEW_AND_POWER_MODE_ADDR && !load_otp && wr_data[7:6] == 2'h3)
        ##1 (!SHUTDOWN && !wr_stb)
        |=> (BUCK_RAMP_SEL[1:0] == 2'h3 && BUCK_RAMP_RATE[13:0] == 14'h2710)
    ) else $error("ramp rate not applied");

    a_sw_off: assert property (
        (src1 == SEQ_SRC_SOFTWARE && mode1 == MODE_OFF) |=> !BUCK_EN[1]
    ) else $error("software off mode left buck on");

    a_sw_group: assert property (
        (src1 == SEQ_SRC_SOFTWARE && mode1 == MODE_GROUP_LP)
        |=> (BUCK_EN[1] && BUCK_LP[1] == $past(GLOBAL_LOW_POWER))
    ) else $error("software group mode wrong");

    a_sw_lowpower: assert property (
        (src1 == SEQ_SRC_SOFTWARE && mode1 == MODE_LOW_POWER) |=> (BUCK_EN[1] && BUCK_LP[1])
    ) else $error("software low power mode wrong");

    a_sw_normal: assert property (
        (src1 == SEQ_SRC_SOFTWARE && mode1 == MODE_NORMAL) |=> (BUCK_EN[1] && !BUCK_LP[1])
    ) else $error("software normal mode wrong");

    a_seq_normal: assert property (
        (src1 != SEQ_SRC_SOFTWARE && (mode1 == MODE_OFF || mode1 == MODE_NORMAL))
        |=> (BUCK_EN[1] == $past(seq_act1) && !BUCK_LP[1])
    ) else $error("sequencer normal mode wrong");

    a_seq_group: assert property (
        (src1 != SEQ_SRC_SOFTWARE && mode1 == MODE_GROUP_LP)
        |=> (BUCK_EN[1] == $past(seq_act1) && BUCK_LP[1] == ($past(seq_act1) && $past(GLOBAL_LOW_POWER)))
    ) else $error("sequencer group mode wrong");

    a_seq_lowpower: assert property (
        (src1 != SEQ_SRC_SOFTWARE && mode1 == MODE_LOW_POWER)
        |=> (BUCK_EN[1] == $past(seq_act1) && BUCK_LP[1] == $past(seq_act1))
    ) else $error("sequencer low power mode wrong");

    a_pin_override: assert property (
        SECOND_ENABLE_PIN |=> BUCK_EN[0]
    ) else $error("enable pin did not turn on buck zero");

    a_input_tracked: assert property (
        ($changed(GLOBAL_LOW_POWER) && SEQ_SRC[1:0] == SEQ_SRC_SOFTWARE
         && state_q.cfg[0][MODE_MSB:MODE_LSB] == MODE_GROUP_LP && !SECOND_ENABLE_PIN)
        |=> (BUCK_LP[0] == $past(GLOBAL_LOW_POWER))
    ) else $error("low power change not followed");

    a_lp_needs_en: assert property (
        (BUCK_LP & ~BUCK_EN) == '0
    ) else $error("low power flagged on a disabled buck");

    a_rate_mid: assert property (
        (BUCK_RAMP_SEL[3:2] == 2'h2)
        |=> (BUCK_RAMP_RATE[27:14] == RAMP_RATE_CODE2)
    ) else $error("buck one ramp rate does not follow code 2");

    a_rate_slow: assert property (
        (BUCK_RAMP_SEL[5:4] == 2'h0)
        |=> (BUCK_RAMP_RATE[41:28] == RAMP_RATE_CODE0)
    ) else $error("buck two ramp rate does not follow code 0");

    a_unmapped_read: assert property (
        (rd_addr < BUCK0_SLEW_AND_POWER_MODE_ADDR || rd_addr > BUCK3_SLEW_AND_POWER_MODE_ADDR)
        |-> (rd_data == UNMAPPED_READ_VALUE)
    ) else $error("unmapped read returned data");

    a_shutdown_buck_zero: assert property (
        SHUTDOWN
        |=> (state_q.cfg[0] == {2'h1, $past(OTP_BITS[2]), $past(OTP_BITS[1]), 2'h0, $past(OTP_BITS[0]), 1'b0})
    ) else $error("buck zero shutdown pattern wrong");

    a_seq_idle_off: assert property (
        (src1 != SEQ_SRC_SOFTWARE && !seq_act1) |=> (!BUCK_EN[1] && !BUCK_LP[1])
    ) else $error("inactive sequencer left buck one on");

    a_write_last_buck: assert property (
        (wr_stb && wr_addr == BUCK3_SLEW_AND_POWER_MODE_ADDR && !load_otp)
        |=> (state_q.cfg[3] == $past(wr_data))
    ) else $error("write to buck three register not stored");

    a_pin_normal: assert property (
        (SECOND_ENABLE_PIN && SEQ_SRC[1:0] == SEQ_SRC_SOFTWARE && state_q.cfg[0][MODE_MSB:MODE_LSB] == MODE_OFF)
        |=> (BUCK_EN[0] && !BUCK_LP[0])
    ) else $error("enable pin override not in normal mode");

endmodule : bcr_config_top
`default_nettype wire

/* dv/bcr_i2c_host.sv */
// Purpose: i2c bus master model driving scl and pulling sda low
// Assumes: open-drain sda with pull-up resolved by the bench
// Notes: each phase lasts 4 clk cycles, signals change right after an edge
`timescale 1ns/1ps
`default_nettype none
module bcr_i2c_host
    import bcr_pkg::*;
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic step(input logic s, input logic d);
        scl <= s;
        sda_low <= d;
        repeat (4) @(posedge clk);
    endtask : step

    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start

    task automatic stop();
        step(1'b0, sda_low);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop

    // data only moves while scl is low
    task automatic bit_out(input logic b, output logic seen);
        step(1'b0, sda_low);
        step(1'b0, ~b);
        step(1'b1, ~b);
        seen = sda;
    endtask : bit_out

    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(tx[i], s);
            rx[i] = s;
        end
        bit_out(mack, s);
        ack = ~s;
    endtask : xfer

    task automatic wr_reg(input logic [6:0] ta, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a;
        start();
        xfer({ta, 1'b0}, 1'b1, rx, ok);
        xfer(ptr, 1'b1, rx, a);
        xfer(d, 1'b1, rx, a);
        stop();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        xfer({I2C_TARGET_ADDR, 1'b0}, 1'b1, rx, a);
        xfer(ptr, 1'b1, rx, a);
        start();
        xfer({I2C_TARGET_ADDR, 1'b1}, 1'b1, rx, a);
        xfer(8'hFF, 1'b1, d, a);
        stop();
    endtask : rd_reg
endmodule : bcr_i2c_host
`default_nettype wire

/* dv/test_buck_regulator_config_reg.sv */
// Purpose: self-checking bench for the buck configuration register bank
// Assumes: integer model of registers and power mode decoder
// Notes: pins randomised from a fixed seed, registers reached over i2c
`timescale 1ns/1ps
`default_nettype none
module test_buck_regulator_config_reg;
    import bcr_pkg::*;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic shutdown = 1'b0;
    logic [11:0] otp;
    logic [7:0] seq_src = 8'h00;
    logic [2:0] seq_act = 3'h0;
    logic glp = 1'b0;
    logic second_enable_pin = 1'b0;
    logic scl, sda_low, sda_o, sda_oe_n, sda_w;
    logic [3:0] buck_en, buck_lp;
    logic [7:0] ramp_sel;
    logic [55:0] ramp_rate;
    int seed = 5147;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int mdl[4];
    int rate[4] = '{1375, 2750, 5500, 10000};
    logic ok;
    logic [7:0] d;

    always #2 clk = ~clk;
    // open drain wire with pull-up
    assign sda_w = ~(sda_low | (~sda_oe_n & ~sda_o));

    bcr_config_top i_dut (.CLK(clk), .RESETN(resetn), .SHUTDOWN(shutdown), .SCL(scl), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .OTP_BITS(otp), .SEQ_SRC(seq_src), .SEQ_ACTIVE(seq_act),
        .GLOBAL_LOW_POWER(glp), .SECOND_ENABLE_PIN(second_enable_pin), .BUCK_EN(buck_en), .BUCK_LP(buck_lp),
        .BUCK_RAMP_SEL(ramp_sel), .BUCK_RAMP_RATE(ramp_rate));
    bcr_i2c_host i_host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : cmp

    task automatic mdl_reset();
        for (int i = 0; i < 4; i++) begin
            mdl[i] = 'h40 | (otp[3*i+2] << 5) | (otp[3*i+1] << 4) | (otp[3*i] << 1);
        end
    endtask : mdl_reset

    task automatic chk_out();
        logic [3:0] en, lp;
        logic [7:0] rs;
        logic [55:0] rr;
        int r, m, s, a;
        for (int i = 0; i < 4; i++) begin
            r = mdl[i];
            m = (r >> 4) & 3;
            s = seq_src[2*i+:2];
            a = (s == 3) ? 1 : seq_act[s];
            en[i] = a != 0 && !(s == 3 && m == 0);
            lp[i] = en[i] && (m == 2 || (m == 1 && glp));
            if (i == 0 && !en[i] && second_enable_pin) begin
                en[i] = 1'b1;
            end
            rs[2*i+:2] = 2'(r >> 6);
            rr[14*i+:14] = 14'(rate[(r >> 6) & 3]);
        end
        cmp("buck_en", 64'(en), 64'(buck_en));
        cmp("buck_lp", 64'(lp), 64'(buck_lp));
        cmp("ramp_sel", 64'(rs), 64'(ramp_sel));
        cmp("ramp_rate", 64'(rr), 64'(ramp_rate));
    endtask : chk_out

    task automatic chk_regs();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            i_host.rd_reg(BUCK0_SLEW_AND_POWER_MODE_ADDR + 8'(i), v);
            cmp("reg", 64'(mdl[i]), 64'(v));
        end
    endtask : chk_regs

    task automatic pins();
        {seq_src, seq_act, glp, second_enable_pin} <= 13'($random(seed));
        repeat (3) @(posedge clk);
        chk_out();
    endtask : pins

    initial begin
        repeat (12) @(posedge clk);
        otp <= 12'($random(seed));
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        mdl_reset();
        chk_out();
        chk_regs();
        $display("test reset_values done");
        // ramp field set once per pass, no ramp in flight
        for (int m = 0; m < 4; m++) begin
            for (int b = 0; b < 4; b++) begin
                d = {2'(m), 2'(m), 4'($random(seed))};
                i_host.wr_reg(I2C_TARGET_ADDR, BUCK0_SLEW_AND_POWER_MODE_ADDR + 8'(b), d, ok);
                cmp("ack", 64'h1, 64'(ok));
                mdl[b] = d;
            end
            repeat (3) @(posedge clk);
            for (int k = 0; k < 24; k++) begin
                pins();
            end
        end
        chk_regs();
        $display("test modes done");
        i_host.wr_reg(I2C_TARGET_ADDR ^ 7'h01, BUCK0_SLEW_AND_POWER_MODE_ADDR, 8'h00, ok);
        cmp("foreign_ack", 64'h0, 64'(ok));
        i_host.wr_reg(I2C_TARGET_ADDR, 8'h21, 8'hFF, ok);
        i_host.wr_reg(I2C_TARGET_ADDR, 8'h1C, 8'hFF, ok);
        i_host.rd_reg(8'h21, d);
        cmp("unmapped", 64'(UNMAPPED_READ_VALUE), 64'(d));
        chk_regs();
        $display("test refused done");
        shutdown <= 1'b1;
        @(posedge clk);
        shutdown <= 1'b0;
        repeat (3) @(posedge clk);
        mdl_reset();
        pins();
        chk_regs();
        $display("test shutdown done");
        i_host.wr_reg(I2C_TARGET_ADDR, BUCK3_SLEW_AND_POWER_MODE_ADDR, 8'hF0, ok);
        cmp("ack_last", 64'h1, 64'(ok));
        mdl[3] = 'hF0;
        pins();
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("en_in_reset", 64'h0, 64'(buck_en));
        cmp("sel_in_reset", 64'h55, 64'(ramp_sel));
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        mdl_reset();
        pins();
        chk_regs();
        $display("test second_reset done");
        test_done();
    end
endmodule : test_buck_regulator_config_reg
`default_nettype wire
